// *** verilog/sccf_top.sv ***
// smart card function general control, subsystem alias and class alias registers
`timescale 1ns/10ps
`default_nettype none
module sccf_top #(
	parameter int OVR_W = sccf_pkg::OVERRIDE_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic func_rst_n,
	input wire sccf_pkg::sccf_cfg_req_t cfg_req,
	input wire sccf_pkg::sccf_ee_req_t ee_req,
	input wire logic ee_done,
	input wire logic [OVR_W-1:0] interrupt_override_terminals,
	output logic [31:0] cfg_rdata,
	output logic cfg_rvalid,
	output logic [7:0] interrupt_pin_register,
	output logic function_hide,
	output logic pci_clk_en,
	output logic clk48_en,
	output logic [15:0] socket_config_mirror,
	output logic load_done
);
	// merges a write under byte enables and a writable-bit mask
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be, input logic [31:0] wmask);
		logic [31:0] bm;
		bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		merge = (old & ~(bm & wmask)) | (wd & bm & wmask);
	endfunction

	// address match for a write strobe; shared by the host and loader decode
	function automatic logic hit(input logic strobe, input logic [7:0] addr,
		input logic [7:0] ofs);
		hit = strobe && (addr == ofs);
	endfunction

	logic [15:0] gen_ctrl_q, gen_ctrl_d;
	logic [31:0] subsys_q, subsys_d;
	logic [31:0] class_q, class_d;
	logic [31:0] rdata_q, rdata_d;
	logic rvalid_q;
	logic [7:0] int_pin_q;
	logic hide_q;
	logic pci_en_q, clk48_en_q;
	logic [15:0] mirror_q;
	logic done_q;
	logic [7:0] pin_w;

	// eeprom writes take priority; host should not write before load completes,
	// since a host write in the same cycle as a loader write to one register is lost
	wire ee_gen = hit(ee_req.wr, ee_req.addr, sccf_pkg::OFS_GEN_CTRL);
	wire ee_sub = hit(ee_req.wr, ee_req.addr, sccf_pkg::OFS_SUBSYS_ALIAS);
	wire ee_cls = hit(ee_req.wr, ee_req.addr, sccf_pkg::OFS_CLASS_ALIAS);
	// host decode; no gating by hide so accesses land even while the function is hidden
	wire hw_gen = hit(cfg_req.wr, cfg_req.addr, sccf_pkg::OFS_GEN_CTRL);
	wire hw_sub = hit(cfg_req.wr, cfg_req.addr, sccf_pkg::OFS_SUBSYS_ALIAS);
	wire hw_cls = hit(cfg_req.wr, cfg_req.addr, sccf_pkg::OFS_CLASS_ALIAS);

	// live fields of the general control register
	wire [sccf_pkg::INT_SEL_W-1:0] int_sel_w =
		gen_ctrl_q[sccf_pkg::INT_SEL_LSB +: sccf_pkg::INT_SEL_W];
	wire hide_w = gen_ctrl_q[sccf_pkg::HIDE_BIT];

	// merged write values; read-only bits keep their zero contents
	wire [31:0] gen_wide = {16'h0000, gen_ctrl_q};
	wire [31:0] gen_ee = merge(gen_wide, ee_req.data, 4'hf, {16'h0000, sccf_pkg::GEN_CTRL_WMASK});
	wire [31:0] gen_hw = merge(gen_wide, cfg_req.wdata, cfg_req.be,
		{16'h0000, sccf_pkg::GEN_CTRL_WMASK});
	wire [31:0] sub_ee = ee_req.data;
	wire [31:0] sub_hw = merge(subsys_q, cfg_req.wdata, cfg_req.be, 32'hffff_ffff);
	wire [31:0] cls_ee = merge(class_q, ee_req.data, 4'hf, sccf_pkg::CLASS_ALIAS_WMASK);
	wire [31:0] cls_hw = merge(class_q, cfg_req.wdata, cfg_req.be,
		sccf_pkg::CLASS_ALIAS_WMASK);

	// next register values; only the masked bits ever change
	assign gen_ctrl_d = ee_gen ? gen_ee[15:0] : (hw_gen ? gen_hw[15:0] : gen_ctrl_q);
	assign subsys_d = ee_sub ? sub_ee : (hw_sub ? sub_hw : subsys_q);
	assign class_d = ee_cls ? cls_ee : (hw_cls ? cls_hw : class_q);

	// read mux; alias halves also show at the standard subsystem slot
	always_comb
	begin
		case (cfg_req.addr)
			sccf_pkg::OFS_GEN_CTRL: rdata_d = {16'h0000, gen_ctrl_q};
			sccf_pkg::OFS_SUBSYS_ALIAS: rdata_d = subsys_q;
			sccf_pkg::OFS_SUBSYS: rdata_d = {subsys_q[sccf_pkg::BOARD_PRODUCT_LSB +: 16],
				subsys_q[sccf_pkg::BOARD_MAKER_LSB +: 16]};
			sccf_pkg::OFS_CLASS_ALIAS: rdata_d = class_q;
			sccf_pkg::OFS_CLASS_REV: rdata_d = {class_q[31:8], sccf_pkg::REVISION_ID};
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	// router is combinational; its answer is registered below so the pin leaves a flop
	sccf_int_route #(
		.OVR_W(OVR_W)
	) u_route (
		.int_sel(int_sel_w),
		.interrupt_override_terminals(interrupt_override_terminals),
		.interrupt_pin(pin_w)
	);

	// general control: global reset only, the function reset leaves it alone
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			gen_ctrl_q <= sccf_pkg::GEN_CTRL_RST;
		else
			gen_ctrl_q <= gen_ctrl_d;
	end

	// subsystem alias: sticky as well, so a loaded identity survives power states
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			subsys_q <= sccf_pkg::SUBSYS_ALIAS_RST;
		else
			subsys_q <= subsys_d;
	end

	// class alias: default class code until the loader or the host replaces it
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			class_q <= sccf_pkg::CLASS_ALIAS_RST;
		else
			class_q <= class_d;
	end

	// load done is sticky; the loader only pulses its done flag
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			done_q <= 1'b0;
		else
			done_q <= done_q | ee_done;
	end

	// read data holds its last value, so a slow host can still pick it up
	always_ff @(posedge clk)
	begin
		if (!rst_n || !func_rst_n)
			rdata_q <= 32'h0000_0000;
		else if (cfg_req.rd)
			rdata_q <= rdata_d;
	end

	// read valid is a one-cycle pulse; the function reset may drop a pending answer
	always_ff @(posedge clk)
	begin
		if (!rst_n || !func_rst_n)
			rvalid_q <= 1'b0;
		else
			rvalid_q <= cfg_req.rd;
	end

	// derived outputs lag the registers by one edge so every pin comes from a flop;
	// a read just after a write shows the new value on the same edge at which the pins take it,
	// since the read data also leaves a flop one edge after the registers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			int_pin_q <= sccf_pkg::INT_PIN_BASE;
		else
			int_pin_q <= pin_w;
	end

	// hide flag and both clock enables share one stage so they always switch together;
	// the enables stand in for gating cells, which must latch them on the low clock phase
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			hide_q <= 1'b0;
			pci_en_q <= 1'b1;
			clk48_en_q <= 1'b1;
		end
		else
		begin
			hide_q <= hide_w;
			pci_en_q <= !hide_w;
			clk48_en_q <= !hide_w;
		end
	end

	// copy for the socket configuration register; reserved bits are zero already
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			mirror_q <= sccf_pkg::GEN_CTRL_RST;
		else
			mirror_q <= gen_ctrl_q;
	end

	// every output is a plain copy of its flop
	assign cfg_rdata = rdata_q;
	assign cfg_rvalid = rvalid_q;
	assign interrupt_pin_register = int_pin_q;
	assign function_hide = hide_q;
	assign pci_clk_en = pci_en_q;
	assign clk48_en = clk48_en_q;
	assign socket_config_mirror = mirror_q;
	assign load_done = done_q;
endmodule
`default_nettype wire

// *** verilog/sccf_pkg.sv ***
// shared constants and carriers for the smart card function config alias bank
package sccf_pkg;
	// register offsets, byte addresses in configuration space
	localparam logic [7:0] OFS_CLASS_REV = 8'h08;
	localparam logic [7:0] OFS_SUBSYS = 8'h2c;
	localparam logic [7:0] OFS_GEN_CTRL = 8'h4c;
	localparam logic [7:0] OFS_SUBSYS_ALIAS = 8'h50;
	localparam logic [7:0] OFS_CLASS_ALIAS = 8'h54;
	// general control field layout
	localparam int INT_SEL_LSB = 5;
	localparam int INT_SEL_W = 2;
	localparam int HIDE_BIT = 4;
	localparam logic [15:0] GEN_CTRL_WMASK = 16'h0070;
	localparam logic [15:0] GEN_CTRL_RST = 16'h0000;
	// subsystem alias halves
	localparam int BOARD_MAKER_LSB = 0;
	localparam int BOARD_PRODUCT_LSB = 16;
	// arbitrary neutral identity value, not any real maker or board
	localparam logic [31:0] SUBSYS_ALIAS_RST = 32'h0001_0001;
	// class code alias, low six bits read as zero
	localparam logic [31:0] CLASS_ALIAS_RST = 32'h0780_0000;
	localparam logic [31:0] CLASS_ALIAS_WMASK = 32'hffff_ffc0;
	// arbitrary neutral revision byte
	localparam logic [7:0] REVISION_ID = 8'h01;
	// interrupt pin codes
	localparam logic [7:0] INT_PIN_BASE = 8'h01;
	localparam int OVERRIDE_W = 4;

	// host configuration access
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} sccf_cfg_req_t;

	// serial eeprom loader write
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [31:0] data;
	} sccf_ee_req_t;
endpackage

// *** verilog/sccf_int_route.sv ***
// interrupt pin selection from the select field and override terminals
`timescale 1ns/10ps
`default_nettype none
module sccf_int_route #(
	parameter int OVR_W = sccf_pkg::OVERRIDE_W
) (
	input wire logic [sccf_pkg::INT_SEL_W-1:0] int_sel,
	input wire logic [OVR_W-1:0] interrupt_override_terminals,
	output logic [7:0] interrupt_pin
);
	// any override wins; lowest asserted terminal decides the pin
	always_comb
	begin
		interrupt_pin = sccf_pkg::INT_PIN_BASE + {6'h00, int_sel};
		for (int i = OVR_W - 1; i >= 0; i--)
		begin
			if (interrupt_override_terminals[i])
				interrupt_pin = sccf_pkg::INT_PIN_BASE + 8'(i);
		end
	end
endmodule
`default_nettype wire

// *** testbench/sccf_top_checker.sv ***
// assertion checker for the config alias bank ports
`timescale 1ns/10ps
`default_nettype none
module sccf_top_checker #(
	parameter int OVR_W = sccf_pkg::OVERRIDE_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire sccf_pkg::sccf_cfg_req_t cfg_req,
	input wire logic [OVR_W-1:0] interrupt_override_terminals,
	input wire logic [31:0] cfg_rdata,
	input wire logic cfg_rvalid,
	input wire logic [7:0] interrupt_pin_register,
	input wire logic function_hide,
	input wire logic pci_clk_en,
	input wire logic clk48_en,
	input wire logic [15:0] socket_config_mirror,
	input wire logic load_done
);
	// one domain, clock and reset given once
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// pin and mirror share one cycle of lag, so they line up
	chk_hide_gates: assert property (pci_clk_en != function_hide
		&& clk48_en != function_hide)
		else $error("clock enable wrong");
	chk_mirror_rsvd: assert property (socket_config_mirror[15:7] == 9'h000
		&& socket_config_mirror[3:0] == 4'h0)
		else $error("mirror reserved bits set");
	chk_mirror_hide: assert property (socket_config_mirror[4] == function_hide)
		else $error("mirror and hide differ");
	chk_sel_pin: assert property ($past(interrupt_override_terminals) == '0
		|-> interrupt_pin_register == {6'h00, socket_config_mirror[6:5]} + 8'h01)
		else $error("pin does not follow select");
	chk_override_pin: assert property ($past(interrupt_override_terminals[0])
		|-> interrupt_pin_register == 8'h01)
		else $error("override ignored");
	chk_gc_rdata: assert property (cfg_req.rd
		&& cfg_req.addr == sccf_pkg::OFS_GEN_CTRL
		|=> cfg_rdata[15:7] == 9'h000 && cfg_rdata[3:0] == 4'h0)
		else $error("control reserved read nonzero");
	chk_class_low: assert property (cfg_req.rd
		&& cfg_req.addr == sccf_pkg::OFS_CLASS_ALIAS
		|=> cfg_rdata[5:0] == 6'h00)
		else $error("class low bits nonzero");
	chk_rvalid_cause: assert property (!cfg_req.rd |=> !cfg_rvalid)
		else $error("read valid without read");
	chk_done_sticky: assert property (load_done |=> load_done)
		else $error("load done dropped");
	cov_hidden: cover property (function_hide);
	cov_class_read: cover property (cfg_req.rd && cfg_req.addr == sccf_pkg::OFS_CLASS_ALIAS);
	cov_override: cover property (interrupt_override_terminals[0]);
	cov_loaded: cover property ($rose(load_done));
endmodule
bind sccf_top sccf_top_checker #(
	.OVR_W(OVR_W)
) u_chk (
	.clk(clk),
	.rst_n(rst_n),
	.cfg_req(cfg_req),
	.interrupt_override_terminals(interrupt_override_terminals),
	.cfg_rdata(cfg_rdata),
	.cfg_rvalid(cfg_rvalid),
	.interrupt_pin_register(interrupt_pin_register),
	.function_hide(function_hide),
	.pci_clk_en(pci_clk_en),
	.clk48_en(clk48_en),
	.socket_config_mirror(socket_config_mirror),
	.load_done(load_done)
);
`default_nettype wire

// *** testbench/sccf_ee_model.sv ***
// serial eeprom loader model, writes the three configuration words after reset
`timescale 1ns/10ps
`default_nettype none
module sccf_ee_model #(
	parameter logic [31:0] WORD = 32'h5a5a_1234,
	parameter logic [31:0] CLS_WORD = 32'h0c03_00ff,
	parameter logic [31:0] GEN_WORD = 32'h0000_ff4f
) (
	input wire logic clk,
	input wire logic rst_n,
	output var sccf_pkg::sccf_ee_req_t ee_req,
	output var logic ee_done
);
	// load starts only once global reset is gone
	initial
	begin
		ee_req = '0;
		ee_done = 1'b0;
		forever
		begin
			@(posedge rst_n);
			repeat (3) @(negedge clk);
			ee_req = '{1'b1, sccf_pkg::OFS_SUBSYS_ALIAS, WORD};
			@(negedge clk);
			ee_req = '{1'b1, sccf_pkg::OFS_CLASS_ALIAS, CLS_WORD};
			@(negedge clk);
			ee_req = '{1'b1, sccf_pkg::OFS_GEN_CTRL, GEN_WORD};
			@(negedge clk);
			ee_req = '0;
			ee_done = 1'b1;
			@(negedge clk);
			ee_done = 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** testbench/sccf_top_bench.sv ***
// randomised bench for the config alias bank
`timescale 1ns/10ps
`default_nettype none
module sccf_top_bench;
	localparam logic [31:0] EE_W = 32'h5a5a_1234;
	localparam logic [31:0] EE_C = 32'h0c03_00ff;
	localparam logic [31:0] EE_G = 32'h0000_ff4f;
	logic clk, rst_n, func_rst_n, ee_done, cfg_rvalid, function_hide, pci_clk_en, clk48_en, load_done;
	sccf_pkg::sccf_cfg_req_t cfg_req;
	sccf_pkg::sccf_ee_req_t ee_req;
	logic [3:0] interrupt_override_terminals, be;
	logic [31:0] cfg_rdata, gc, sa, ca, d;
	logic [7:0] interrupt_pin_register, a;
	logic [15:0] socket_config_mirror;
	logic [7:0] rt [6] = '{8'h08, 8'h2c, 8'h4c, 8'h50, 8'h54, 8'h60};
	int n_mismatch = 0, num_checks = 0, seed = 60, i;
	sccf_top dut (
		.clk(clk),
		.rst_n(rst_n),
		.func_rst_n(func_rst_n),
		.cfg_req(cfg_req),
		.ee_req(ee_req),
		.ee_done(ee_done),
		.interrupt_override_terminals(interrupt_override_terminals),
		.cfg_rdata(cfg_rdata),
		.cfg_rvalid(cfg_rvalid),
		.interrupt_pin_register(interrupt_pin_register),
		.function_hide(function_hide),
		.pci_clk_en(pci_clk_en),
		.clk48_en(clk48_en),
		.socket_config_mirror(socket_config_mirror),
		.load_done(load_done)
	);
	sccf_ee_model #(
		.WORD(EE_W),
		.CLS_WORD(EE_C),
		.GEN_WORD(EE_G)
	) u_ee (
		.clk(clk),
		.rst_n(rst_n),
		.ee_req(ee_req),
		.ee_done(ee_done)
	);
	// compare helpers and the expected-value model
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] m);
		logic [31:0] k;
		for (int j = 0; j < 4; j++) k[8*j+:8] = {8{be[j]}};
		return (o & ~(k & m)) | (d & k & m);
	endfunction
	function automatic logic [31:0] exp_rd(input logic [7:0] ad);
		case (ad)
			8'h08: return {ca[31:8], sccf_pkg::REVISION_ID};
			8'h2c, 8'h50: return sa;
			8'h4c: return gc;
			8'h54: return ca;
			default: return 32'h0;
		endcase
	endfunction
	function automatic logic [7:0] exp_pin();
		for (int j = 0; j < 4; j++) if (interrupt_override_terminals[j]) return 8'(j + 1);
		return {6'h0, gc[6:5]} + 8'h01;
	endfunction
	// one access: request held one cycle, read answer seen the next
	task automatic acc(input logic w, input logic [7:0] ad);
		@(negedge clk);
		cfg_req = '{w, !w, ad, be, d};
		@(negedge clk);
		cfg_req = '0;
		if (!w) chk(cfg_rvalid, 32'h1);
		if (!w) chk(cfg_rdata, exp_rd(ad));
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// whole run is well under a thousand cycles
	initial
	begin
		#20000;
		n_mismatch++;
		end_of_test();
	end
	initial
	begin
		rst_n = 0; func_rst_n = 1; cfg_req = '0; interrupt_override_terminals = 0; be = 4'hf; d = 0;
		gc = EE_G & {16'h0000, sccf_pkg::GEN_CTRL_WMASK};
		sa = EE_W;
		ca = EE_C & sccf_pkg::CLASS_ALIAS_WMASK;
		repeat (20) @(negedge clk);
		rst_n = 1;
		for (i = 0; i < 50 && load_done !== 1'b1; i++) @(negedge clk);
		chk(load_done, 1);
		for (i = 0; i < 6; i++) acc(0, rt[i]);
		chk(interrupt_pin_register, exp_pin());
		$display("reset and load test done");
		for (i = 0; i < 40; i++)
		begin
			a = rt[2 + $unsigned($random(seed)) % 4];
			be = 4'($random(seed));
			d = $random(seed);
			if (i < 4) {a, be, d} = {rt[i % 3 + 2 + i / 3], 4'hf, (i == 3) ? 32'h0 : 32'hffff_ffff};
			interrupt_override_terminals = ($random(seed) & 1) ? 4'($random(seed)) : 4'h0;
			acc(1, a);
			gc = mrg(gc, a == 8'h4c ? {16'h0, sccf_pkg::GEN_CTRL_WMASK} : 32'h0);
			sa = mrg(sa, a == 8'h50 ? 32'hffff_ffff : 32'h0);
			ca = mrg(ca, a == 8'h54 ? sccf_pkg::CLASS_ALIAS_WMASK : 32'h0);
			acc(0, a);
			acc(0, rt[$unsigned($random(seed)) % 6]);
			chk(function_hide, gc[4]);
			chk({pci_clk_en, clk48_en}, {2{!gc[4]}});
			chk(socket_config_mirror, gc[15:0]);
			chk(interrupt_pin_register, exp_pin());
		end
		$display("random access test done");
		func_rst_n = 0;
		repeat (2) @(negedge clk);
		func_rst_n = 1;
		acc(0, 8'h4c);
		acc(0, 8'h50);
		$display("function reset test done");
		end_of_test();
	end
endmodule
`default_nettype wire
